// File: pkg/sync_cfg.svh
// Purpose: constants for the generator-to-bus synchronizer block
// Assumes: 250 MHz clock, all inputs synchronous to clk
// Notes: phase and slip measurements are signed fixed point, rms voltages unsigned, scale chosen by the integrator
//
// Overview of operation
// - sync type selects phase match, slip frequency or off, exclusively
// - mode follows the most recent mode command from any source
// - off mode disables automatic biases and closure; entered on no auto, off, success
// - in off mode operator raise/lower pass to speed and voltage bias
// - run mode needs auto; biases and closure automatic, operator ignored
// - run keeps speed bias, and voltage bias if enabled, during closure
// - run turns off on closure time expiry or aux contact feedback
// - check mode needs auto; matches speed and voltage, never closes
// - permissive needs auto; closes when in limits, operator biases pass
// - voltage matching disabled holds voltage bias at zero in check and run; off and permissive pass operator bias
// - dead bus when bus voltage below range-selected threshold of three
// - dead bus closure needs bus breaker open, enable, and dead voltage
// - slip mode regulates to slip offset, accepts deviation within slip window
// - slip mode closes on a live bus only while phase error inside phase window
// - phase mode uses slip as maximum frequency difference, ignores window
// - phase mode biases against the phase error only while phase outside window
// - phase difference of generator and bus phase A exposed as monitor
// - speed correction is PI with separate proportional and integral gains
// - voltage match drives raise/lower until in window, then holds
// - voltage matched actively in check and run, verified in permissive
// - voltage adjust limit alarm when bias at limit without match
// - voltage matching and dead bus closure individually enabled through configuration; the other feature bits are not used
// - closure command held for configured hold time awaiting feedback
`ifndef SYNC_CFG_SVH
`define SYNC_CFG_SVH
`define SYNC_MODE_CMD_W 2
`define SYNC_TYPE_W 2
`define SYNC_MEAS_W 16
`define SYNC_BIAS_W 16
`define SYNC_HOLD_W 32
`define SYNC_HOLD_RST 32'h0000_0000
`define SYNC_HOLD_LAST 32'h0000_0001
`define SYNC_BIAS_ZERO 16'sh0000
`define SYNC_VSTEP 16'sh0001
`define SYNC_MANUAL_STEP 16'sh0010
`define SYNC_ACC_W 32
`define SYNC_ACC_ZERO 32'sh0000_0000
`define SYNC_GAIN_SHIFT 8
`define SYNC_RANGE_LOW 2'h0
`define SYNC_RANGE_MID 2'h1
`define SYNC_DEAD_LOW_VAC 27
`define SYNC_DEAD_MID_VAC 40
`define SYNC_DEAD_HIGH_VAC 80
`endif

// File: pkg/sync_pkg.sv
// Purpose: types shared by the synchronizer files
// Assumes: sync_cfg.svh constants
// Notes: none
package sync_pkg;
   typedef enum logic [1:0] {mode_off, mode_check, mode_permissive, mode_run} sync_mode_e;
   typedef enum logic [1:0] {type_off, type_phase, type_slip} sync_type_e;
   // feature enables, one bit each
   typedef struct packed {
      logic volt_match;
      logic reclose;
      logic contactor;
      logic timeout_alarm;
      logic rotation_alarm;
      logic fail_sync_alarm;
      logic fail_close_alarm;
      logic dead_bus;
   } sync_feat_s;
   // operator panel switches
   typedef struct packed {
      logic speed_raise;
      logic speed_lower;
      logic volt_raise;
      logic volt_lower;
   } panel_sw_s;
endpackage

// File: core/sync_pi.sv
// Purpose: proportional-integral speed correction
// Assumes: error is signed, gains unsigned, result scaled down by a shift
// Notes: integrator cleared while disabled so a fresh start does not kick
`timescale 1ns/1ps
`default_nettype none
`include "sync_cfg.svh"
module sync_pi #(
   parameter int W = `SYNC_BIAS_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic enable,
   input wire logic signed [W-1:0] err,
   input wire logic [7:0] kp,
   input wire logic [7:0] ki,
   // result
   output logic signed [W-1:0] out
);
   logic signed [`SYNC_ACC_W-1:0] integ_ff;
   logic signed [`SYNC_ACC_W-1:0] sum;

   // integral state, held at zero when idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         integ_ff <= `SYNC_ACC_ZERO;
      end else if (!enable) begin
         integ_ff <= `SYNC_ACC_ZERO;
      end else begin
         integ_ff <= integ_ff + `SYNC_ACC_W'(err) * $signed({1'b0, ki});
      end
   end

   // pi sum
   // error widened first so the product keeps all of its bits
   assign sum = `SYNC_ACC_W'(err) * $signed({1'b0, kp}) + integ_ff;

   // result register, truncated to output width; gains must keep the sum in range
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         out <= '0;
      end else begin
         out <= W'(sum >>> `SYNC_GAIN_SHIFT);
      end
   end
endmodule
`default_nettype wire

// File: core/sync_ctrl.sv
// Purpose: synchronizer mode control, speed and voltage bias, breaker closure
// Assumes: measurements arrive synchronous to clk, already scaled
// Notes: reclosing, timeout and rotation checks live elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "sync_cfg.svh"
module sync_ctrl
   import sync_pkg::*;
#(
   parameter int MW = `SYNC_MEAS_W,
   parameter int BW = `SYNC_BIAS_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // mode command
   input wire logic mode_cmd_valid,
   input wire sync_mode_e mode_cmd,
   input wire logic auto_sw,
   // configuration
   input wire sync_type_e sync_type,
   input wire sync_feat_s feat,
   input wire logic [1:0] sense_range,
   input wire logic [MW-1:0] slip_freq,
   input wire logic [MW-1:0] slip_window,
   input wire logic [MW-1:0] phase_window,
   input wire logic [MW-1:0] volt_window,
   input wire logic [BW-1:0] bias_limit,
   input wire logic [7:0] kp,
   input wire logic [7:0] ki,
   input wire logic [`SYNC_HOLD_W-1:0] hold_cycles,
   // operator panel
   input wire panel_sw_s panel,
   // measurements
   input wire logic signed [MW-1:0] gen_phase_a,
   input wire logic signed [MW-1:0] bus_phase_a,
   input wire logic signed [MW-1:0] slip_meas,
   input wire logic [MW-1:0] gen_vrms,
   input wire logic [MW-1:0] bus_vrms,
   // breakers
   input wire logic gen_aux_closed,
   input wire logic bus_aux_closed,
   // outputs
   output logic signed [BW-1:0] speed_bias,
   output logic signed [BW-1:0] volt_bias,
   output logic breaker_close,
   output logic signed [MW-1:0] phase_monitor,
   output logic dead_bus,
   output logic volt_limit_alarm,
   output sync_mode_e mode
);
   // ----------------
   // internal state
   // ----------------
   sync_mode_e mode_ff, last_cmd_ff, nxt_mode;
   logic [`SYNC_HOLD_W-1:0] hold_ff;
   logic signed [BW-1:0] vbias_ff;
   logic signed [BW-1:0] manual_ff;
   logic signed [BW-1:0] mvolt_ff;
   logic signed [MW-1:0] phase_ff;
   logic signed [BW-1:0] pi_out;
   logic signed [MW-1:0] speed_err;
   logic closing, close_ok, phase_in, freq_in, volt_in, done;
   logic close_mode;
   logic signed [MW:0] vdiff;
   logic [MW-1:0] dead_level;

   // ----------------
   // helper functions
   // ----------------
   // magnitude of a signed value
   function automatic logic [MW-1:0] mag(input logic signed [MW-1:0] v);
      mag = v[MW-1] ? MW'(-v) : v;
   endfunction

   // step a bias toward a direction, bounded by limit
   function automatic logic signed [BW-1:0] step(input logic signed [BW-1:0] b,
         input logic up, input logic dn, input logic signed [BW-1:0] s,
         input logic [BW-1:0] lim);
      step = b;
      if (up && b < $signed(lim)) step = b + s;
      else if (dn && b > -$signed(lim)) step = b - s;
   endfunction

   // ----------------
   // mode control
   // ----------------
   // latest mode command wins
   // a success clears the latched command, so the block stays off until told again
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_cmd_ff <= mode_off;
      end else if (mode_cmd_valid) begin
         last_cmd_ff <= mode_cmd;
      end else if (done) begin
         last_cmd_ff <= mode_off;
      end
   end

   always_comb begin
      nxt_mode = last_cmd_ff;
      if (!auto_sw || sync_type == type_off || done) begin
         nxt_mode = mode_off;
      end
   end

   // mode register, follows the resolved mode one edge later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_ff <= mode_off;
      end else begin
         mode_ff <= nxt_mode;
      end
   end
   assign mode = mode_ff;

   // ----------------
   // measurements
   // ----------------
   // phase difference monitor
   // registered so the monitor and the window test see the same sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= '0;
      end else begin
         phase_ff <= MW'(gen_phase_a - bus_phase_a);
      end
   end
   assign phase_monitor = phase_ff;

   always_comb begin
      if (sense_range == `SYNC_RANGE_LOW) begin
         dead_level = MW'(`SYNC_DEAD_LOW_VAC);
      end else if (sense_range == `SYNC_RANGE_MID) begin
         dead_level = MW'(`SYNC_DEAD_MID_VAC);
      end else begin
         dead_level = MW'(`SYNC_DEAD_HIGH_VAC);
      end
   end
   // levels compare straight against the rms word; scaling is left to the integrator
   assign dead_bus = bus_vrms < dead_level;

   // ----------------
   // closure conditions
   // ----------------
   // generator minus bus, one bit wider so the sign survives
   assign vdiff = $signed({1'b0, gen_vrms}) - $signed({1'b0, bus_vrms});
   // window edges count as inside
   assign phase_in = mag(phase_ff) <= phase_window;
   // voltage window, verified only when matching enabled
   assign volt_in = !feat.volt_match || (mag(MW'(vdiff)) <= volt_window);
   // frequency test depends on the synchronizing type
   always_comb begin
      freq_in = 1'b0;
      case (sync_type)
         type_slip: freq_in = mag(MW'(slip_meas - $signed(slip_freq))) <= slip_window;
         type_phase: freq_in = mag(slip_meas) <= slip_freq;
         default: freq_in = 1'b0;
      endcase
   end
   // phase window required for live bus
   assign close_ok = (feat.dead_bus && !bus_aux_closed && dead_bus) ||
                     (phase_in && freq_in && volt_in);

   // ----------------
   // breaker closure
   // ----------------
   // closure only in run or permissive
   // present and next mode are both checked, so a mode change never leaves
   // the command standing in check or off for a cycle
   assign close_mode = (mode_ff == mode_run || mode_ff == mode_permissive) &&
                       (nxt_mode == mode_run || nxt_mode == mode_permissive);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ff <= `SYNC_HOLD_RST;
      end else if (!close_mode) begin
         hold_ff <= `SYNC_HOLD_RST;
      end else if (hold_ff != `SYNC_HOLD_RST) begin
         hold_ff <= hold_ff - 1'b1;
      end else if (close_ok && !gen_aux_closed && !breaker_close) begin
         // a contact already closed refuses a fresh closure
         hold_ff <= hold_cycles;
      end
   end
   assign closing = hold_ff != `SYNC_HOLD_RST;
   assign breaker_close = closing;
   // expiry or aux feedback ends run
   assign done = closing && (hold_ff == `SYNC_HOLD_LAST || gen_aux_closed);

   // ----------------
   // speed loop
   // ----------------
   // speed error: slip target in slip mode, phase in phase mode
   // phase mode corrects only outside the window
   always_comb begin
      speed_err = '0;
      if (sync_type == type_slip) begin
         speed_err = MW'($signed(slip_freq) - slip_meas);
      end else if (sync_type == type_phase && !phase_in) begin
         speed_err = MW'(-phase_ff);
      end
   end

   // pi runs only while the loop is in charge, so its integral starts clean
   sync_pi #(.W(BW)) u_pi (
      .clk(clk),
      .rst_n(rst_n),
      .enable(mode_ff == mode_check || mode_ff == mode_run),
      .err(BW'(speed_err)),
      .kp(kp),
      .ki(ki),
      .out(pi_out)
   );

   // manual speed bias accumulator
   // operator steps also count in permissive, where the panel drives the biases
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         manual_ff <= `SYNC_BIAS_ZERO;
      end else if (mode_ff == mode_off || mode_ff == mode_permissive) begin
         manual_ff <= step(manual_ff, panel.speed_raise, panel.speed_lower,
                           `SYNC_MANUAL_STEP, bias_limit);
      end
   end

   // manual voltage bias accumulator
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mvolt_ff <= `SYNC_BIAS_ZERO;
      end else if (mode_ff == mode_off || mode_ff == mode_permissive) begin
         mvolt_ff <= step(mvolt_ff, panel.volt_raise, panel.volt_lower,
                          `SYNC_MANUAL_STEP, bias_limit);
      end
   end

   // ----------------
   // voltage loop
   // ----------------
   // automatic voltage match in check and run
   // bias holds inside the window and resumes once the window is left
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vbias_ff <= `SYNC_BIAS_ZERO;
      end else if (feat.volt_match && !volt_in &&
                   (mode_ff == mode_check || mode_ff == mode_run)) begin
         vbias_ff <= step(vbias_ff, vdiff < 0, vdiff > 0, `SYNC_VSTEP, bias_limit);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         volt_limit_alarm <= 1'b0;
      end else begin
         volt_limit_alarm <= feat.volt_match && !volt_in &&
            (vbias_ff >= $signed(bias_limit) || vbias_ff <= -$signed(bias_limit));
      end
   end

   // ----------------
   // bias outputs
   // ----------------
   // output selection per mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         speed_bias <= `SYNC_BIAS_ZERO;
         volt_bias <= `SYNC_BIAS_ZERO;
      end else begin
         case (mode_ff)
            mode_check, mode_run: begin
               speed_bias <= pi_out;
               volt_bias <= feat.volt_match ? vbias_ff : `SYNC_BIAS_ZERO;
            end
            default: begin
               speed_bias <= manual_ff;
               volt_bias <= mvolt_ff;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: dv/sync_ctrl_monitor.sv
// Purpose: port-level checks of the synchronizer control block
// Assumes: one clock domain, async active-low reset
// Notes: bound to every sync_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module sync_ctrl_monitor
   import sync_pkg::*;
#(
   parameter int MW = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // inputs watched
   input wire logic mode_cmd_valid,
   input wire sync_mode_e mode_cmd,
   input wire logic auto_sw,
   input wire sync_type_e sync_type,
   input wire logic [1:0] sense_range,
   input wire logic [31:0] hold_cycles,
   input wire logic signed [MW-1:0] gen_phase_a,
   input wire logic signed [MW-1:0] bus_phase_a,
   input wire logic [MW-1:0] bus_vrms,
   input wire logic gen_aux_closed,
   // outputs watched
   input wire logic breaker_close,
   input wire logic signed [MW-1:0] phase_monitor,
   input wire logic dead_bus,
   input wire sync_mode_e mode
);
   // ----------------
   // closure length
   // ----------------
   logic [31:0] on_ff;
   // cycles the close command has already stood
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_ff <= 32'h0;
      end else begin
         on_ff <= breaker_close ? on_ff + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   cmd_follow_a: assert property (mode_cmd_valid ##1 (!mode_cmd_valid && auto_sw
      && sync_type != type_off && !breaker_close) |=> mode == $past(mode_cmd, 2))
      else $error("cmd");
   no_auto_a: assert property (!auto_sw |=> mode == mode_off) else $error("auto");
   type_off_a: assert property (sync_type == type_off |=> mode == mode_off)
      else $error("type off");
   check_close_a: assert property (mode == mode_check |-> !breaker_close)
      else $error("check closed");
   close_src_a: assert property ($rose(breaker_close) |->
      $past(mode) inside {mode_run, mode_permissive}) else $error("close source");
   close_len_a: assert property (breaker_close |-> on_ff < hold_cycles)
      else $error("close too long");
   aux_end_a: assert property (breaker_close && gen_aux_closed |-> ##[1:2] !breaker_close)
      else $error("aux end");
   off_after_a: assert property ($fell(breaker_close) |-> ##[0:2] mode == mode_off)
      else $error("not off");
   dead_lvl_a: assert property (dead_bus == (bus_vrms < ((sense_range == 2'h0) ? 16'h1b :
      (sense_range == 2'h1) ? 16'h28 : 16'h50))) else $error("dead level");
   phase_mon_a: assert property ($past(rst_n) |->
      phase_monitor == $past(gen_phase_a) - $past(bus_phase_a)) else $error("phase");
endmodule
bind sync_ctrl sync_ctrl_monitor #(.MW(MW)) mon (.clk, .rst_n, .mode_cmd_valid, .mode_cmd,
   .auto_sw, .sync_type, .sense_range, .hold_cycles, .gen_phase_a, .bus_phase_a,
   .bus_vrms, .gen_aux_closed, .breaker_close, .phase_monitor, .dead_bus, .mode);
`default_nettype wire

// File: dv/breaker_model.sv
// Purpose: generator breaker with auxiliary contact
// Assumes: delay 0 models a breaker that never closes
// Notes: contact stays closed until tripped
`timescale 1ns/1ps
`default_nettype none
module breaker_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // commands
   input wire logic close_cmd,
   input wire logic [7:0] delay,
   input wire logic trip,
   // feedback
   output logic aux_closed
);
   logic [7:0] cnt_ff;
   logic aux_ff;
   // contact answers after delay cycles of close command
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 8'h00;
         aux_ff <= 1'b0;
      end else begin
         cnt_ff <= close_cmd ? cnt_ff + 8'h01 : 8'h00;
         if (trip) begin
            aux_ff <= 1'b0;
         end else if (close_cmd && delay != 8'h00 && cnt_ff + 8'h01 == delay) begin
            aux_ff <= 1'b1;
         end
      end
   end
   assign aux_closed = aux_ff;
endmodule
`default_nettype wire

// File: dv/sync_ctrl_bench.sv
// Purpose: directed tests of the synchronizer control block
// Assumes: inputs change 1 ns after the rising edge
// Notes: short hold time keeps closures brief
`timescale 1ns/1ps
`default_nettype none
module sync_ctrl_bench
   import sync_pkg::*;
;
   localparam int HOLD = 5;
   logic clk = 0, rst_n = 0, vld = 0, auto_sw = 0, trip = 0, bus_aux = 1, gen_aux, bc, dead, alarm;
   sync_mode_e cmd = mode_off, mode;
   sync_type_e st = type_phase;
   sync_feat_s feat = 8'h01;
   panel_sw_s panel = 4'h0;
   logic [1:0] rng = 2'h0;
   logic [15:0] win = 16'h0010, lim = 16'h0100, gph = 16'h0000, bv = 16'h0064, pm;
   logic signed [15:0] sb, vb;
   logic [7:0] gain = 8'h01, dly = 8'h00;
   int err_total = 0, tests_run = 0, n, len;
   sync_ctrl uut (.clk(clk), .rst_n(rst_n), .mode_cmd_valid(vld), .mode_cmd(cmd),
      .auto_sw(auto_sw), .sync_type(st), .feat(feat), .sense_range(rng), .slip_freq(win),
      .slip_window(win), .phase_window(win), .volt_window(win), .bias_limit(lim),
      .kp(gain), .ki(gain), .hold_cycles(32'(HOLD)), .panel(panel), .gen_phase_a(gph),
      .bus_phase_a(16'h0000), .slip_meas(16'h0000), .gen_vrms(16'h0064), .bus_vrms(bv),
      .gen_aux_closed(gen_aux), .bus_aux_closed(bus_aux), .speed_bias(sb), .volt_bias(vb),
      .breaker_close(bc), .phase_monitor(pm), .dead_bus(dead), .volt_limit_alarm(alarm),
      .mode(mode));
   breaker_model brk (.clk(clk), .rst_n(rst_n), .close_cmd(bc), .delay(dly), .trip(trip),
      .aux_closed(gen_aux));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // command held one edge; go lowers valid afterwards
   task automatic send(input sync_mode_e m);
      vld = 1;
      cmd = m;
      cyc(1);
   endtask
   task automatic go(input sync_mode_e m);
      send(m);
      vld = 0;
      cyc(1);
   endtask
   // bounded wait for a closure, then its length in cycles
   task automatic closure;
      n = 0;
      while (bc !== 1'b1 && n < 50) begin
         n++;
         cyc(1);
      end
      len = 0;
      while (bc === 1'b1 && len < 50) begin
         len++;
         cyc(1);
      end
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ----------------
   // test sequence
   // ----------------
   initial begin
      cyc(10);
      rst_n = 1;
      chk("mode", mode_off, mode);
      go(mode_run);
      chk("mode", mode_off, mode);
      auto_sw = 1;
      st = type_off;
      go(mode_run);
      chk("mode", mode_off, mode);
      st = type_phase;
      go(mode_check);
      chk("mode", mode_check, mode);
      cyc(20);
      chk("close", 0, bc);
      chk("vbias", 0, vb);
      send(mode_permissive);
      go(mode_off);
      chk("mode", mode_off, mode);
      panel = 4'ha;
      cyc(4);
      chk("sraise", 1, sb > 0);
      chk("vraise", 1, vb > 0);
      panel = 4'h0;
      for (int r = 0; r < 4; r++) begin
         rng = r[1:0];
         bv = (r == 0) ? 16'h1b : (r == 1) ? 16'h28 : 16'h50;
         cyc(1);
         chk("live", 0, dead);
         bv = bv - 16'h1;
         cyc(1);
         chk("dead", 1, dead);
      end
      rng = 2'h0;
      gph = 16'h4000;
      bv = 16'h0000;
      go(mode_run);
      chk("mode", mode_run, mode);
      chk("phase", 16'h4000, pm);
      cyc(20);
      chk("close", 0, bc);
      chk("sbias", 1, sb < 0);
      bus_aux = 0;
      closure();
      chk("hold", HOLD, len);
      cyc(2);
      chk("mode", mode_off, mode);
      dly = 8'h02;
      go(mode_permissive);
      closure();
      chk("short", 1, len < HOLD);
      cyc(2);
      chk("mode", mode_off, mode);
      // voltage matching: bus above generator drives bias up to its limit
      feat = 8'h81;
      bv = 16'h0084;
      go(mode_check);
      chk("mode", mode_check, mode);
      cyc(300);
      chk("vmatch", lim, vb);
      chk("vlimit", 1, alarm);
      // inside the window but on the other side: bias must hold, not step down
      bv = 16'h0058;
      cyc(4);
      chk("vhold", lim, vb);
      chk("vlimit", 0, alarm);
      finish_test();
   end
   initial begin
      #20000;
      err_total++;
      finish_test();
   end
endmodule
`default_nettype wire
